// *** hdl/gsm_regs.sv ***
`default_nettype none

module gsm_regs (
    // clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             rst_n,
    // register access port from the management bus front end
    input  wire logic [gsm_pkg::ADDR_W-1:0]       reg_addr,
    input  wire logic                             reg_wr_en,
    input  wire logic [gsm_pkg::DATA_W-1:0]       reg_wdata,
    input  wire logic                             reg_rd_en,
    output logic      [gsm_pkg::DATA_W-1:0]       reg_rdata,
    output logic                                  reg_rd_valid,
    // pin configuration held by the neighbouring configuration registers
    input  wire logic [gsm_pkg::NUM_PINS-1:0]     pin_dir_out,
    input  wire logic [gsm_pkg::DATA_W-1:0]       pin_cfg_three,
    input  wire logic [gsm_pkg::DATA_W-1:0]       pin_cfg_four,
    // general-purpose pins, bit i is gp_pin_(8+i)
    input  wire logic [gsm_pkg::NUM_PINS-1:0]     gp_pin_in,
    output logic      [gsm_pkg::NUM_PINS-1:0]     gp_pin_out,
    output logic      [gsm_pkg::NUM_PINS-1:0]     gp_pin_oe,
    // conversion results from the measurement logic
    input  wire logic                             bat_res_valid,
    input  wire logic [gsm_pkg::DATA_W-1:0]       bat_res_data,
    input  wire logic                             aux8_res_valid,
    input  wire logic [gsm_pkg::DATA_W-1:0]       aux8_res_data,
    input  wire logic                             rtemp1_res_valid,
    input  wire logic [gsm_pkg::DATA_W-1:0]       rtemp1_res_data
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // polarity bit of pin idx (0..7) taken from the right config register
    function automatic logic pol_bit(
        input logic [gsm_pkg::DATA_W-1:0] cfg_lo,
        input logic [gsm_pkg::DATA_W-1:0] cfg_hi,
        input int unsigned                idx
    );
        int unsigned pos;
        pos = gsm_pkg::POL_BIT_FIRST + gsm_pkg::POL_BIT_STEP * (idx % gsm_pkg::PINS_PER_CFG);
        if (idx < gsm_pkg::PINS_PER_CFG)
        begin
            return cfg_lo[pos];
        end
        return cfg_hi[pos];
    endfunction : pol_bit

    // maps between pin level and asserted state; the mapping is its own inverse
    function automatic logic assert_map(
        input logic lvl,
        input logic pol
    );
        return (pol == gsm_pkg::POL_ACTIVE_HIGH) ? lvl : ~lvl;
    endfunction : assert_map

    function automatic logic addr_is(
        input logic [gsm_pkg::ADDR_W-1:0] addr,
        input logic [gsm_pkg::ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction : addr_is

    // next asserted state of one status bit; input pins never take a host write
    function automatic logic status_next(
        input logic cur,
        input logic is_out,
        input logic wr_hit,
        input logic wr_bit,
        input logic pin_lvl,
        input logic pin_pol
    );
        logic nxt;
        nxt = cur;
        if (!is_out)
        begin
            // input pins track the pin, so a write there would be lost next cycle anyway
            nxt = assert_map(pin_lvl, pin_pol);
        end
        else if (wr_hit)
        begin
            nxt = wr_bit;
        end
        return nxt;
    endfunction : status_next

    // read answer for one offset; an unmapped offset answers a fixed byte
    function automatic logic [gsm_pkg::DATA_W-1:0] read_mux(
        input logic [gsm_pkg::ADDR_W-1:0] addr,
        input logic [gsm_pkg::DATA_W-1:0] status,
        input logic [gsm_pkg::DATA_W-1:0] bat,
        input logic [gsm_pkg::DATA_W-1:0] aux8,
        input logic [gsm_pkg::DATA_W-1:0] rtemp1
    );
        logic [gsm_pkg::DATA_W-1:0] data;
        // fixed distinct offsets, so at most one arm can match
        unique case (1'b1)
            addr_is(addr, gsm_pkg::OFS_PIN_STATUS_HIGH_GROUP):
                data = status;
            addr_is(addr, gsm_pkg::OFS_BATTERY_VOLTAGE):
                data = bat;
            addr_is(addr, gsm_pkg::OFS_AUX_ANALOG_EIGHT):
                data = aux8;
            addr_is(addr, gsm_pkg::OFS_REMOTE_TEMP_ONE):
                data = rtemp1;
            default:
                data = gsm_pkg::UNMAPPED_BYTE;
        endcase
        return data;
    endfunction : read_mux

    ////////////////////////////////////////////////////////////////////////////
    // measurement result holders

    logic [gsm_pkg::DATA_W-1:0] bat_value;
    logic [gsm_pkg::DATA_W-1:0] aux8_value;
    logic [gsm_pkg::DATA_W-1:0] rtemp1_value;

    gsm_result_hold #(
        .W         (gsm_pkg::DATA_W)
    ) u_bat_hold (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .res_valid (bat_res_valid),
        .res_data  (bat_res_data),
        .value     (bat_value)
    );

    gsm_result_hold #(
        .W         (gsm_pkg::DATA_W)
    ) u_aux8_hold (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .res_valid (aux8_res_valid),
        .res_data  (aux8_res_data),
        .value     (aux8_value)
    );

    gsm_result_hold #(
        .W         (gsm_pkg::DATA_W)
    ) u_rtemp1_hold (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .res_valid (rtemp1_res_valid),
        .res_data  (rtemp1_res_data),
        .value     (rtemp1_value)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin status and read path

    gsm_pkg::gsm_state_t state_ff;
    gsm_pkg::gsm_state_t nxt_state;

    logic                         wr_status;
    logic [gsm_pkg::NUM_PINS-1:0] pol;

    always_comb
    begin
        nxt_state = state_ff;
        wr_status = reg_wr_en && addr_is(reg_addr, gsm_pkg::OFS_PIN_STATUS_HIGH_GROUP);
        pol       = '0;

        for (int unsigned i = 0; i < gsm_pkg::NUM_PINS; i++)
        begin
            pol[i] = pol_bit(pin_cfg_three, pin_cfg_four, i);
            nxt_state.status[i] = status_next(state_ff.status[i], pin_dir_out[i], wr_status,
                                              reg_wdata[i], gp_pin_in[i], pol[i]);
            // the level follows a polarity change even without a new write
            nxt_state.pin_out[i] = assert_map(nxt_state.status[i], pol[i]);
            nxt_state.pin_oe[i]  = pin_dir_out[i];
        end

        // writes to the result offsets fall through here and are dropped
        nxt_state.rvalid = reg_rd_en;
        if (reg_rd_en)
        begin
            // a read beside a write in one cycle answers the value before it
            nxt_state.rdata = read_mux(reg_addr, state_ff.status, bat_value, aux8_value,
                                       rtemp1_value);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_ff.status  <= gsm_pkg::RESET_BYTE;
            state_ff.pin_out <= '0;
            state_ff.pin_oe  <= '0;
            state_ff.rdata   <= gsm_pkg::RESET_BYTE;
            state_ff.rvalid  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata    = state_ff.rdata;
    assign reg_rd_valid = state_ff.rvalid;
    assign gp_pin_out   = state_ff.pin_out;
    assign gp_pin_oe    = state_ff.pin_oe;

endmodule : gsm_regs

`default_nettype wire

// *** inc/gsm_pkg.sv ***
`default_nettype none

package gsm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned NUM_PINS     = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_PIN_STATUS_HIGH_GROUP = 8'h25;
    localparam logic [ADDR_W-1:0] OFS_BATTERY_VOLTAGE       = 8'h26;
    localparam logic [ADDR_W-1:0] OFS_AUX_ANALOG_EIGHT      = 8'h27;
    localparam logic [ADDR_W-1:0] OFS_REMOTE_TEMP_ONE       = 8'h28;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and read answer for unmapped offsets
    localparam logic [DATA_W-1:0] RESET_BYTE    = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // polarity field layout in the third and fourth pin configuration registers
    localparam int unsigned PINS_PER_CFG    = 4;
    localparam int unsigned POL_BIT_FIRST   = 1;
    localparam int unsigned POL_BIT_STEP    = 2;
    // polarity bit value that selects active high
    localparam logic        POL_ACTIVE_HIGH = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // state records
    typedef struct packed {
        logic [NUM_PINS-1:0] status;
        logic [NUM_PINS-1:0] pin_out;
        logic [NUM_PINS-1:0] pin_oe;
        logic [DATA_W-1:0]   rdata;
        logic                rvalid;
    } gsm_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] value;
    } gsm_hold_state_t;

endpackage : gsm_pkg

`default_nettype wire

// *** hdl/gsm_result_hold.sv ***
`default_nettype none

// holds the latest result of one measurement channel
module gsm_result_hold #(
    parameter int unsigned W = gsm_pkg::DATA_W
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // result from the measurement logic
    input  wire logic         res_valid,
    input  wire logic [W-1:0] res_data,
    // stored value
    output logic      [W-1:0] value
);

    gsm_pkg::gsm_hold_state_t state_ff;
    gsm_pkg::gsm_hold_state_t nxt_state;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_state = state_ff;
        // only a delivered conversion moves the value, never the host
        if (res_valid)
        begin
            nxt_state.value = res_data[W-1:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_ff.value <= W'(gsm_pkg::RESET_BYTE);
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign value = state_ff.value;

endmodule : gsm_result_hold

`default_nettype wire

// *** bench/gsm_regs_sva.sv ***
`default_nettype none
module gsm_regs_sva (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rd_valid,
    // pins
    input wire logic [7:0] pin_dir_out,
    input wire logic [7:0] pin_cfg_three,
    input wire logic [7:0] pin_cfg_four,
    input wire logic [7:0] gp_pin_out,
    input wire logic [7:0] gp_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    wire logic wr_all = reg_wr_en && reg_addr == 8'h25 && pin_dir_out == 8'hff;
    wire logic pol_hi = ((pin_cfg_three & pin_cfg_four) & 8'haa) == 8'haa;
    wire logic pol_lo = ((pin_cfg_three | pin_cfg_four) & 8'haa) == 8'h00;
    property p_rd_lat;
        reg_rd_en |=> reg_rd_valid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
    property p_rd_pulse;
        !reg_rd_en |=> !reg_rd_valid;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("stray answer");
    property p_hold;
        !reg_rd_en |=> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap;
        reg_rd_en && !(reg_addr inside {[8'h25:8'h28]}) |=> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rst;
        $rose(rst_n) |-> gp_pin_out == 8'h00 && gp_pin_oe == 8'h00 && reg_rdata == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_oe;
        $past(rst_n) |-> gp_pin_oe == $past(pin_dir_out);
    endproperty
    a_oe: assert property (p_oe) else $error("enable not direction");
    property p_wr_hi;
        wr_all && pol_hi |=> gp_pin_out == $past(reg_wdata);
    endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("high drive wrong");
    property p_wr_lo;
        wr_all && pol_lo |=> gp_pin_out == ~$past(reg_wdata);
    endproperty
    a_wr_lo: assert property (p_wr_lo) else $error("low drive wrong");
    c_read: cover property (reg_rd_valid);
    c_wr_hi: cover property (wr_all && pol_hi);
    c_wr_lo: cover property (wr_all && pol_lo);
endmodule : gsm_regs_sva
bind gsm_regs gsm_regs_sva gsm_regs_sva_inst (.*);
`default_nettype wire

// *** bench/gsm_regs_bench.sv ***
`default_nettype none
module gsm_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       rst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
    logic       bat_res_valid, aux8_res_valid, rtemp1_res_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_dir_out, pin_cfg_three, pin_cfg_four;
    logic [7:0] gp_pin_in, gp_pin_out, gp_pin_oe, bat_res_data, aux8_res_data, d;
    logic [7:0] rtemp1_res_data;
    logic [7:0] expq[$];
    int         errors, compares;
    integer     seed;
    gsm_regs gsm_regs_inst (.clk_sys, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rdata, .reg_rd_valid, .pin_dir_out, .pin_cfg_three, .pin_cfg_four, .gp_pin_in,
        .gp_pin_out, .gp_pin_oe, .bat_res_valid, .bat_res_data, .aux8_res_valid,
        .aux8_res_data, .rtemp1_res_valid, .rtemp1_res_data);
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_pin(input logic [7:0] exp);
        chk(gp_pin_out, exp);
    endtask : chk_pin
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        {reg_addr, reg_wdata, reg_wr_en} = {a, v, 1'b1};
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        {reg_addr, reg_rd_en} = {a, 1'b1};
        expq.push_back(e);
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
    endtask : rd
    // odd bits (1, 3, 5, 7) of a config register set mean active high
    function automatic logic [7:0] pol();
        return {pin_cfg_four[7], pin_cfg_four[5], pin_cfg_four[3], pin_cfg_four[1],
                pin_cfg_three[7], pin_cfg_three[5], pin_cfg_three[3], pin_cfg_three[1]};
    endfunction : pol
    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    ////////////////////////////////////////
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys)
        if (reg_rd_valid === 1'b1)
            chk(reg_rdata, expq.pop_front());
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        errors++;
        conclude();
    end
    initial
    begin
        {rst_n, reg_wr_en, reg_rd_en, reg_addr, reg_wdata, pin_dir_out} = '0;
        {pin_cfg_three, pin_cfg_four, gp_pin_in, bat_res_valid, bat_res_data} = '0;
        {aux8_res_valid, aux8_res_data, rtemp1_res_valid, rtemp1_res_data} = '0;
        seed = 32'h9b61;
        // active-high polarity with pins low keeps the status byte at its reset value
        {pin_cfg_three, pin_cfg_four} = 16'hffff;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int a = 0; a < 6; a++) rd(8'h24 + 8'(a), 8'h00);
        $display("reset values done");
        @(negedge clk_sys);
        {bat_res_valid, aux8_res_valid, rtemp1_res_valid} = 3'b111;
        {bat_res_data, aux8_res_data, rtemp1_res_data} = 24'($random(seed));
        @(negedge clk_sys);
        {bat_res_valid, aux8_res_valid, rtemp1_res_valid} = 3'b000;
        // data moves without a strobe: stored results must not follow
        {bat_res_data, aux8_res_data, rtemp1_res_data} = ~{bat_res_data, aux8_res_data,
            rtemp1_res_data};
        for (int i = 0; i < 3; i++) wr(8'h26 + 8'(i), 8'($random(seed)));
        rd(8'h26, ~bat_res_data);
        rd(8'h27, ~aux8_res_data);
        rd(8'h28, ~rtemp1_res_data);
        $display("results done");
        for (int k = 0; k < 4; k++)
        begin
            {pin_cfg_three, pin_cfg_four, gp_pin_in} = 24'($random(seed));
            wr(8'h25, 8'($random(seed)));
            rd(8'h25, gp_pin_in ^ ~pol());
        end
        chk(gp_pin_oe, 8'h00);
        $display("input pins done");
        pin_dir_out = 8'hff;
        for (int k = 0; k < 4; k++)
        begin
            {pin_cfg_three, pin_cfg_four} = k == 0 ? 16'hffff : k == 1 ? 16'h0000
                                          : 16'($random(seed));
            d = 8'($random(seed));
            wr(8'h25, d);
            chk_pin(d ^ ~pol());
            rd(8'h25, d);
        end
        // polarity flip alone, no write: the drive level must follow one edge later
        {pin_cfg_three, pin_cfg_four} = ~{pin_cfg_three, pin_cfg_four};
        @(negedge clk_sys);
        chk_pin(d ^ ~pol());
        chk(gp_pin_oe, 8'hff);
        pin_dir_out = 8'h0f;
        d = 8'($random(seed));
        wr(8'h25, d);
        rd(8'h25, (d & 8'h0f) | ((gp_pin_in ^ ~pol()) & 8'hf0));
        $display("output pins done");
        wait (expq.size() == 0);
        repeat (3) @(negedge clk_sys);
        conclude();
    end
endmodule : gsm_regs_bench
`default_nettype wire
